/* File: src/sfwg_guard.sv */
// Write guard, protection decode and hold control of the serial flash
`timescale 1ns/10ps
`default_nettype none
`include "sfwg_consts.svh"
module sfwg_guard #(
   parameter int AW = 24,
   parameter logic VOLATILE_INIT = 1'b0,
   parameter logic [2:0] BP_INIT = 3'h0,
   parameter logic ORIGIN_INIT = 1'b0,
   parameter logic QUAD_INIT = 1'b0
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic cs_n_i,
   input wire logic sck_i,
   input wire logic si_i,
   input wire logic hold_n_i,
   input wire logic write_protect_accel_pin_i,
   input wire logic accel_hv_i,
   input wire logic busy_i,
   input wire logic op_done_i,
   output logic so_o,
   output logic so_oe_o,
   output logic op_start_o,
   output sfwg_pkg::sfwg_op_type op_kind_o,
   output logic [AW-1:0] op_addr_o,
   output logic op_reject_o,
   output logic write_enable_latch_o,
   output logic [2:0] block_protect_o,
   output logic status_write_lock_o,
   output logic protect_origin_sel_o,
   output logic protect_bits_volatile_o,
   output logic quad_mode_o,
   output logic freeze_o,
   output logic hardware_protect_mode_o,
   output logic hold_active_o,
   output logic accel_program_o,
   output logic io2_data_o,
   output logic io3_data_o
);
   // ****************************************************************
   // Pin synchronisation and edge detection
   // ****************************************************************
   logic [5:0] sync_q;
   logic cs_s, sck_s, si_s, hold_s, wp_s, hv_s;
   logic cs_q_r, sck_q_r, hold_q_r;

   sfwg_sync #(.W(6), .INIT(`SFWG_SYNC_INIT)) u_sync (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .d_i({accel_hv_i, write_protect_accel_pin_i, hold_n_i, si_i, sck_i,
            cs_n_i}),
      .q_o(sync_q)
   );
   assign {hv_s, wp_s, hold_s, si_s, sck_s, cs_s} = sync_q;

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cs_q_r <= 1'b1;
         sck_q_r <= 1'b0;
         hold_q_r <= 1'b1;
      end else begin
         cs_q_r <= cs_s;
         sck_q_r <= sck_s;
         hold_q_r <= hold_s;
      end
   end

   logic cs_fall, cs_rise, sck_rise, sck_fall, hold_fall, hold_rise;
   assign cs_fall = cs_q_r & ~cs_s;
   assign cs_rise = ~cs_q_r & cs_s;
   assign sck_rise = ~sck_q_r & sck_s;
   assign sck_fall = sck_q_r & ~sck_s;
   assign hold_fall = hold_q_r & ~hold_s;
   assign hold_rise = ~hold_q_r & hold_s;

   // ****************************************************************
   // Functions
   // ****************************************************************
   function automatic logic prot_hit(input logic [AW-1:0] addr,
                                     input logic [2:0] bp,
                                     input logic origin);
      logic [AW-1:0] mask;
      mask = AW'(`SFWG_ADDR_ONES) << (`SFWG_REGION_SHIFT + int'(bp));
      if (bp == `SFWG_BP_NONE)
         prot_hit = 1'b0;
      else if (bp == `SFWG_BP_ALL)
         prot_hit = 1'b1;
      else if (origin)
         prot_hit = (addr & mask) == '0; // [RULE5]
      else
         prot_hit = (addr & mask) == mask; // [RULE4]
   endfunction : prot_hit

   function automatic sfwg_pkg::sfwg_op_type op_decode(input logic [7:0] c);
      unique case (c)
         `SFWG_OP_PP_CODE: op_decode = sfwg_pkg::SFWG_OP_PROG;
         `SFWG_OP_QPP_CODE: op_decode = sfwg_pkg::SFWG_OP_QPROG;
         `SFWG_OP_OTP_CODE: op_decode = sfwg_pkg::SFWG_OP_OTP;
         `SFWG_OP_SE_CODE: op_decode = sfwg_pkg::SFWG_OP_SECT;
         `SFWG_OP_P4E_CODE: op_decode = sfwg_pkg::SFWG_OP_PSMALL;
         `SFWG_OP_P8E_CODE: op_decode = sfwg_pkg::SFWG_OP_PDOUBLE;
         `SFWG_OP_BE_CODE: op_decode = sfwg_pkg::SFWG_OP_BULK;
         default: op_decode = sfwg_pkg::SFWG_OP_NONE;
      endcase
   endfunction : op_decode

   // ****************************************************************
   // Link state: idle, shifting, hold
   // ****************************************************************
   sfwg_pkg::sfwg_link_type st_r;
   logic quad_r;

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r <= sfwg_pkg::SFWG_LS_IDLE;
      end else begin
         unique case (st_r)
            sfwg_pkg::SFWG_LS_IDLE: begin
               if (cs_fall)
                  st_r <= sfwg_pkg::SFWG_LS_ACTIVE;
            end
            sfwg_pkg::SFWG_LS_ACTIVE: begin
               if (cs_rise)
                  st_r <= sfwg_pkg::SFWG_LS_IDLE;
               else if (!quad_r && ((hold_fall && !sck_s) ||
                                    (!hold_s && sck_fall))) // [RULE10] [RULE16]
                  st_r <= sfwg_pkg::SFWG_LS_HOLD;
            end
            sfwg_pkg::SFWG_LS_HOLD: begin
               // Select rising here drops the frame without executing it
               if (cs_rise)
                  st_r <= sfwg_pkg::SFWG_LS_IDLE; // [RULE14]
               else if ((hold_rise && !sck_s) || (hold_s && sck_fall))
                  st_r <= sfwg_pkg::SFWG_LS_ACTIVE; // [RULE11]
            end
            default: st_r <= sfwg_pkg::SFWG_LS_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Command shifter
   // ****************************************************************
   logic [2:0] bit_cnt_r, byte_cnt_r;
   logic [7:0] shift_r, opcode_r, sr_data_r, cr_data_r;
   logic [AW-1:0] addr_r;
   logic [7:0] byte_nxt;
   logic take;

   assign byte_nxt = {shift_r[6:0], si_s};
   // Clock and data are only looked at outside hold
   assign take = (st_r == sfwg_pkg::SFWG_LS_ACTIVE) && sck_rise; // [RULE12]

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bit_cnt_r <= 3'h0;
         byte_cnt_r <= 3'h0;
         shift_r <= 8'h00;
         opcode_r <= 8'h00;
         sr_data_r <= 8'h00;
         cr_data_r <= 8'h00;
         addr_r <= '0;
      end else if (cs_fall) begin
         bit_cnt_r <= 3'h0;
         byte_cnt_r <= 3'h0;
      end else if (take) begin
         shift_r <= byte_nxt;
         bit_cnt_r <= bit_cnt_r + 3'h1;
         if (bit_cnt_r == 3'h7) begin
            if (byte_cnt_r != 3'h7)
               byte_cnt_r <= byte_cnt_r + 3'h1;
            if (byte_cnt_r == 3'h0)
               opcode_r <= byte_nxt;
            if (byte_cnt_r == 3'h1)
               sr_data_r <= byte_nxt;
            if (byte_cnt_r == 3'h2)
               cr_data_r <= byte_nxt;
            if (byte_cnt_r >= 3'h1 && byte_cnt_r <= 3'h3)
               addr_r <= {addr_r[AW-9:0], byte_nxt};
         end
      end
   end

   // ****************************************************************
   // Command execution at the end of a frame
   // ****************************************************************
   logic frame_end, aligned, hw_protect, wrr_ok, arr_req, hit;
   sfwg_pkg::sfwg_op_type kind;
   logic wel_r, status_write_lock_r, origin_r, volatile_r, freeze_r;
   logic [2:0] bp_r;

   // A frame cut short by select in hold never reaches here
   assign frame_end = (st_r == sfwg_pkg::SFWG_LS_ACTIVE) && cs_rise;
   assign aligned = bit_cnt_r == 3'h0; // [RULE8]
   // Pin function is lost in quad mode
   assign hw_protect = status_write_lock_r & ~wp_s & ~quad_r; // [RULE6]
   assign kind = op_decode(opcode_r);
   assign wrr_ok = frame_end && aligned && !busy_i && wel_r &&
                   opcode_r == `SFWG_OP_WRR_CODE && byte_cnt_r >= 3'h2;
   assign arr_req = frame_end && aligned && !busy_i && wel_r && // [RULE21]
                    kind != sfwg_pkg::SFWG_OP_NONE &&
                    ((kind == sfwg_pkg::SFWG_OP_BULK) ? byte_cnt_r == 3'h1
                                                      : byte_cnt_r >= 3'h4);
   assign hit = (kind == sfwg_pkg::SFWG_OP_OTP) ? 1'b0 :
                (kind == sfwg_pkg::SFWG_OP_BULK) ? bp_r != `SFWG_BP_NONE :
                prot_hit(addr_r, bp_r, origin_r); // [RULE3]

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i)
         wel_r <= 1'b0; // [RULE2]
      else if (frame_end && aligned && !busy_i && byte_cnt_r == 3'h1 &&
               opcode_r == `SFWG_OP_WRITE_ENABLE_CMD_CODE)
         wel_r <= 1'b1; // [RULE1]
      else if (op_done_i || wrr_ok ||
               (frame_end && aligned && opcode_r == `SFWG_OP_WRITE_DISABLE_CMD_CODE))
         wel_r <= 1'b0; // [RULE2]
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         status_write_lock_r <= 1'b0;
         bp_r <= VOLATILE_INIT ? `SFWG_BP_ALL : BP_INIT; // [RULE20]
         origin_r <= ORIGIN_INIT;
         volatile_r <= VOLATILE_INIT;
         quad_r <= QUAD_INIT;
         freeze_r <= 1'b0;
      end else if (wrr_ok) begin
         if (!hw_protect) begin
            status_write_lock_r <= sr_data_r[`SFWG_SR_LOCK]; // [RULE7]
            if (!freeze_r)
               bp_r <= sr_data_r[`SFWG_SR_BP_HI:`SFWG_SR_BP_LO]; // [RULE7]
         end
         // Origin, volatile and freeze bits can only be set, never cleared
         if (byte_cnt_r >= 3'h3 && !freeze_r) begin
            origin_r <= origin_r | cr_data_r[`SFWG_CR_ORIGIN];
            volatile_r <= volatile_r | cr_data_r[`SFWG_CR_VOLATILE];
            quad_r <= cr_data_r[`SFWG_CR_QUAD];
            freeze_r <= cr_data_r[`SFWG_CR_FREEZE];
         end
      end
   end

   // The operation itself runs in the array; hold cannot reach it
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         op_start_o <= 1'b0;
         op_reject_o <= 1'b0;
         op_kind_o <= sfwg_pkg::SFWG_OP_NONE;
         op_addr_o <= '0;
      end else begin
         op_start_o <= arr_req && !hit; // [RULE9]
         op_reject_o <= arr_req && hit; // [RULE22]
         if (arr_req) begin
            op_kind_o <= kind;
            op_addr_o <= addr_r;
         end
      end
   end

   // ****************************************************************
   // Status read-out, pin reuse and acceleration
   // ****************************************************************
   logic [7:0] out_sh_r, status_c;
   logic rd_active;

   assign status_c = {status_write_lock_r, 2'b00, bp_r, wel_r, busy_i};
   assign rd_active = opcode_r == `SFWG_OP_RDSR_CODE && byte_cnt_r != 3'h0;
   assign so_oe_o = (st_r == sfwg_pkg::SFWG_LS_ACTIVE) && rd_active; // [RULE12]

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         out_sh_r <= 8'h00;
         so_o <= 1'b0;
      end else if (take && bit_cnt_r == 3'h7) begin
         out_sh_r <= status_c;
      end else if (st_r == sfwg_pkg::SFWG_LS_ACTIVE && sck_fall) begin
         so_o <= out_sh_r[7];
         out_sh_r <= {out_sh_r[6:0], out_sh_r[7]};
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         io2_data_o <= 1'b0;
         io3_data_o <= 1'b0;
         accel_program_o <= 1'b0;
      end else begin
         io2_data_o <= quad_r & wp_s; // [RULE17]
         io3_data_o <= quad_r & hold_s; // [RULE17]
         accel_program_o <= hv_s & ~quad_r; // [RULE18] [RULE19]
      end
   end

   assign write_enable_latch_o = wel_r;
   assign block_protect_o = bp_r;
   assign status_write_lock_o = status_write_lock_r;
   assign protect_origin_sel_o = origin_r;
   assign protect_bits_volatile_o = volatile_r;
   assign quad_mode_o = quad_r;
   assign freeze_o = freeze_r;
   assign hardware_protect_mode_o = hw_protect;
   assign hold_active_o = st_r == sfwg_pkg::SFWG_LS_HOLD;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   chk_wel_set_enable: assert property ( // [RULE1]
      frame_end && aligned && !busy_i && byte_cnt_r == 3'h1 &&
      opcode_r == `SFWG_OP_WRITE_ENABLE_CMD_CODE |=> wel_r && write_enable_latch_o)
      else $error("latch not set by write enable");
   chk_wel_clear_done: assert property ( // [RULE2]
      op_done_i |=> !wel_r) else $error("latch not cleared on completion");
   chk_prot_refused: assert property ( // [RULE22]
      arr_req && hit |=> op_reject_o && !op_start_o)
      else $error("protected target was not refused");
   chk_start_needs_wel: assert property ( // [RULE21]
      op_start_o |-> $past(wel_r, 1) && $past(aligned, 1))
      else $error("operation started without latch or alignment");
   chk_unaligned_ignored: assert property ( // [RULE8]
      frame_end && !aligned |=> !op_start_o && !op_reject_o && $stable(bp_r))
      else $error("unaligned frame executed");
   chk_hwp_status_lock: assert property ( // [RULE7]
      hw_protect |=> $stable(status_write_lock_r) && $stable(bp_r))
      else $error("status bits changed under hardware protection");
   chk_hold_so_float: assert property ( // [RULE12]
      hold_active_o |-> !so_oe_o) else $error("output driven in hold");
   chk_quad_no_hold: assert property ( // [RULE16]
      quad_r && st_r == sfwg_pkg::SFWG_LS_ACTIVE |=> !hold_active_o)
      else $error("hold entered in quad mode");
   chk_hold_enter: assert property ( // [RULE10]
      st_r == sfwg_pkg::SFWG_LS_ACTIVE && !quad_r && !cs_rise &&
      hold_fall && !sck_s |=> hold_active_o)
      else $error("hold not entered");
   chk_cs_hold_reset: assert property ( // [RULE14]
      hold_active_o && cs_rise |=> st_r == sfwg_pkg::SFWG_LS_IDLE ##0
      !op_start_o) else $error("select in hold did not reset link");
   chk_accel_quad: assert property ( // [RULE18]
      quad_r && $past(quad_r, 1) |-> !accel_program_o)
      else $error("acceleration active in quad mode");
endmodule : sfwg_guard
`default_nettype wire

/* File: src/sfwg_consts.svh */
// Constants of the serial flash write guard and hold block
// Summary of operation
// RULE1: Host sends write enable first; device sets write enable latch on it.
// RULE2: Latch clears at reset and when any modifying command finishes.
// RULE3: Protected region may be read but program and erase are refused.
// RULE4: Origin bit 0: codes protect top 1/64 doubling up to all.
// RULE5: Origin bit 1: codes protect from zero, 256 KB doubling up to all.
// RULE6: Hardware protection is write-protect pin low combined with lock bit.
// RULE7: Under hardware protection lock bit and block-protect bits are read-only.
// RULE8: Modifying commands run only if clock count is a multiple of eight.
// RULE9: Hold pauses the link but never stops an operation in progress.
// RULE10: Hold starts at hold fall with clock low, else next clock fall.
// RULE11: Hold ends at hold rise with clock low, else next clock fall.
// RULE12: In hold the output floats and clock and data are ignored.
// RULE13: Host keeps select low during hold to keep command state.
// RULE14: Select going high during hold resets the serial interface logic.
// RULE15: Host raises hold before lowering select when resuming.
// RULE16: Hold function is disabled while quad mode is on.
// RULE17: Quad mode turns write-protect pin into IO2 and hold into IO3.
// RULE18: Accelerated programming is disabled while quad mode is on.
// RULE19: Shortened program timing only while high voltage sits on the pin.
// RULE20: Volatile protect configuration loads block-protect bits with 111 at reset.
// RULE21: Modifying commands with latch clear are ignored completely.
// RULE22: Program or erase aimed into protected range is rejected.
`ifndef SFWG_CONSTS_SVH
`define SFWG_CONSTS_SVH
// ****************************************************************
// Command opcodes
// ****************************************************************
`define SFWG_OP_WRITE_ENABLE_CMD_CODE 8'h06
`define SFWG_OP_WRITE_DISABLE_CMD_CODE 8'h04
`define SFWG_OP_WRR_CODE 8'h01
`define SFWG_OP_RDSR_CODE 8'h05
`define SFWG_OP_PP_CODE 8'h02
`define SFWG_OP_QPP_CODE 8'h32
`define SFWG_OP_OTP_CODE 8'h42
`define SFWG_OP_SE_CODE 8'hD8
`define SFWG_OP_P4E_CODE 8'h20
`define SFWG_OP_P8E_CODE 8'h40
`define SFWG_OP_BE_CODE 8'hC7
// ****************************************************************
// Register field positions
// ****************************************************************
`define SFWG_SR_LOCK 7
`define SFWG_SR_BP_HI 4
`define SFWG_SR_BP_LO 2
`define SFWG_SR_WEL 1
`define SFWG_SR_BUSY 0
`define SFWG_CR_ORIGIN 5
`define SFWG_CR_VOLATILE 3
`define SFWG_CR_QUAD 1
`define SFWG_CR_FREEZE 0
// ****************************************************************
// Reset values and protection geometry
// ****************************************************************
`define SFWG_BP_NONE 3'h0
`define SFWG_BP_ALL 3'h7
`define SFWG_REGION_SHIFT 17
`define SFWG_ADDR_ONES 24'hFFFFFF
`define SFWG_SYNC_INIT 6'h19
`endif

/* File: src/sfwg_pkg.sv */
// Types of the serial flash write guard and hold block
package sfwg_pkg;
   typedef enum logic [1:0] {
      SFWG_LS_IDLE = 2'b00,
      SFWG_LS_ACTIVE = 2'b01,
      SFWG_LS_HOLD = 2'b11
   } sfwg_link_type;

   typedef enum logic [2:0] {
      SFWG_OP_NONE = 3'h0,
      SFWG_OP_PROG = 3'h1,
      SFWG_OP_QPROG = 3'h2,
      SFWG_OP_OTP = 3'h3,
      SFWG_OP_SECT = 3'h4,
      SFWG_OP_PSMALL = 3'h5,
      SFWG_OP_PDOUBLE = 3'h6,
      SFWG_OP_BULK = 3'h7
   } sfwg_op_type;
endpackage : sfwg_pkg

/* File: src/sfwg_sync.sv */
// Two-flop synchroniser bank for pins entering the core clock
`timescale 1ns/10ps
`default_nettype none
module sfwg_sync #(
   parameter int W = 6,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_r;

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_r <= INIT;
         q_o <= INIT;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule : sfwg_sync
`default_nettype wire

/* File: tb/sfwg_host.sv */
// SPI host model driving select, clock, data and hold of the guard
`timescale 1ns/10ps
`default_nettype none
module sfwg_host #(
   parameter int HALF = 20
) (
   input wire logic mclk_i,
   output logic cs_n_o,
   output logic sck_o,
   output logic si_o,
   output logic hold_n_o
);
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      si_o = 1'b0;
      hold_n_o = 1'b1;
   end

   task automatic step(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : step

   // Hold is raised first so the device cannot fall back into hold
   task automatic sel(input logic v);
      step(1);
      if (!v && !hold_n_o) begin
         hold_n_o = 1'b1;
         step(HALF);
      end
      cs_n_o = v;
      if (v) begin
         si_o = ~si_o; // Released line must not look like held data
      end
      step(HALF);
   endtask : sel

   // Mode 0, data left aligned in d, most significant bit first
   task automatic bits(input logic [31:0] d, input int n);
      for (int i = 0; i < n; i++) begin
         si_o = d[31 - i];
         step(HALF);
         sck_o = 1'b1;
         step(HALF);
         sck_o = 1'b0;
      end
   endtask : bits

   task automatic pins(input logic sck_v, input logic hold_v);
      step(1);
      sck_o = sck_v;
      hold_n_o = hold_v;
   endtask : pins

   task automatic frame(input logic [31:0] d, input int n);
      sel(1'b0);
      bits(d, n);
      sel(1'b1);
   endtask : frame
endmodule : sfwg_host
`default_nettype wire

/* File: tb/sfwg_guard_tb_top.sv */
// Self-checking bench of the serial flash write guard and hold block
`timescale 1ns/10ps
`default_nettype none
module sfwg_guard_tb_top;
   localparam logic [7:0] OPS [7] = '{8'h02, 8'h32, 8'h42, 8'hD8, 8'h20,
      8'h40, 8'hC7};
   logic mclk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic cs_n, sck, si, hold_n, so, so_oe, start, reject, write_enable_latch, lock;
   logic wp = 1'b1;
   logic hv = 1'b0;
   logic busy = 1'b0;
   logic done = 1'b0;
   logic origin, quad, hardware_protect_mode, hold_act, accel, io2, io3, vol, frz;
   sfwg_pkg::sfwg_op_type kind;
   logic [23:0] addr;
   logic [2:0] bp;
   int n_mismatch = 0;
   int comparisons = 0;
   int n_start = 0;
   int n_reject = 0;
   int busy_left = 0;

   sfwg_guard #(.VOLATILE_INIT(1'b1)) dut (.mclk_i(mclk_i), .nrst_i(nrst_i),
      .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .hold_n_i(hold_n),
      .write_protect_accel_pin_i(wp), .accel_hv_i(hv), .busy_i(busy),
      .op_done_i(done), .so_o(so), .so_oe_o(so_oe), .op_start_o(start),
      .op_kind_o(kind), .op_addr_o(addr), .op_reject_o(reject),
      .write_enable_latch_o(write_enable_latch), .block_protect_o(bp),
      .status_write_lock_o(lock), .protect_origin_sel_o(origin),
      .protect_bits_volatile_o(vol), .quad_mode_o(quad), .freeze_o(frz),
      .hardware_protect_mode_o(hardware_protect_mode), .hold_active_o(hold_act),
      .accel_program_o(accel), .io2_data_o(io2), .io3_data_o(io3));
   sfwg_host host (.mclk_i(mclk_i), .cs_n_o(cs_n), .sck_o(sck), .si_o(si),
      .hold_n_o(hold_n));

   always #2 mclk_i = ~mclk_i;

   // ****************************************************************
   // Array stand-in: busy for ten cycles after each start
   // ****************************************************************
   always @(posedge mclk_i) begin
      #1;
      done = 1'b0;
      if (start === 1'b1) begin
         n_start++;
         busy_left = 10;
      end else if (busy_left > 0) begin
         busy_left--;
         done = (busy_left == 0);
      end
      busy = (busy_left > 0);
      if (reject === 1'b1) n_reject++;
   end

   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %0h expected %0h", $time,
            what, got, exp);
      end
   endtask : chk

   task automatic cmd(input logic [7:0] op, input logic [23:0] a,
                      input int n);
      host.frame({op, a}, n);
      host.step(8);
   endtask : cmd

   task automatic write_enable_cmd;
      cmd(8'h06, 24'h000000, 8);
   endtask : write_enable_cmd

   task automatic register_write_cmd(input logic [7:0] st, input logic [7:0] cf);
      write_enable_cmd;
      host.frame({8'h01, st, cf, 8'h00}, 24);
      host.step(8);
   endtask : register_write_cmd

   task automatic report_and_stop;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_commands;
      int s;
      s = n_start;
      cmd(8'hD8, 24'h123456, 32);
      chk(n_start - s, 0, "erase without latch");
      for (int i = 0; i < 7; i++) begin
         write_enable_cmd;
         chk(write_enable_latch, 1, "latch after enable");
         cmd(OPS[i], 24'h123400, OPS[i] == 8'hC7 ? 8 : 32);
         chk(n_start - s, i + 1, "start count");
         chk(kind, i + 1, "op kind"); // Kind codes follow table order
         if (i < 6) chk(addr, 24'h123400, "op addr");
         host.step(20);
         chk(write_enable_latch, 0, "latch after done");
      end
      write_enable_cmd;
      cmd(8'hD8, 24'h123400, 31);
      chk(n_start - s, 7, "odd clock count");
      cmd(8'h04, 24'h000000, 8);
      chk(write_enable_latch, 0, "latch after disable");
   endtask : t_commands

   task automatic t_protect;
      logic [24:0] size;
      logic [23:0] pa;
      int s, r;
      for (int o = 0; o < 2; o++) begin
         for (int c = 1; c < 8; c++) begin
            size = 25'h0040000 << (c - 1);
            pa = o ? size[23:0] - 24'h000001 : 24'h000000 - size[23:0];
            register_write_cmd({3'h0, c[2:0], 2'h0}, {2'h0, o[0], 5'h00});
            chk(bp, c, "block protect code");
            s = n_start;
            r = n_reject;
            write_enable_cmd;
            cmd(8'hD8, pa, 32);
            chk(n_reject - r, 1, "reject in range");
            chk(n_start - s, 0, "no start in range");
            if (c < 7) begin
               cmd(8'hD8, o ? pa + 24'h000001 : pa - 24'h000001, 32);
               chk(n_start - s, 1, "start outside");
               host.step(20);
            end
         end
      end
      register_write_cmd(8'h00, 8'h20);
   endtask : t_protect

   task automatic t_hwprot;
      register_write_cmd(8'h84, 8'h20);
      wp = 1'b0;
      host.step(8);
      chk(hardware_protect_mode, 1, "hardware protect on");
      register_write_cmd(8'h00, 8'h20);
      chk({lock, bp}, 4'h9, "locked bits kept");
      wp = 1'b1;
      host.step(8);
      chk(hardware_protect_mode, 0, "hardware protect off");
      register_write_cmd(8'h00, 8'h20);
      chk({lock, bp}, 4'h0, "bits written");
   endtask : t_hwprot

   task automatic t_hold;
      host.sel(1'b0);
      host.bits(32'h05000000, 8);
      host.step(6);
      chk(so_oe, 1, "status read drives");
      host.pins(1'b0, 1'b0);
      host.step(6);
      chk({hold_act, so_oe}, 2'h2, "hold entered");
      host.bits(32'hFFFFFFFF, 3); // Clock and data ignored in hold
      chk(hold_act, 1, "hold kept");
      host.pins(1'b0, 1'b1);
      host.step(6);
      chk({hold_act, so_oe}, 2'h1, "hold left");
      host.pins(1'b1, 1'b1);
      host.pins(1'b1, 1'b0);
      host.step(6);
      chk(hold_act, 0, "no hold with clock high");
      host.pins(1'b0, 1'b0);
      host.step(6);
      chk(hold_act, 1, "hold at clock fall");
      host.pins(1'b1, 1'b0);
      host.pins(1'b1, 1'b1);
      host.step(6);
      chk(hold_act, 1, "hold until clock fall");
      host.pins(1'b0, 1'b1);
      host.step(6);
      chk(hold_act, 0, "left at clock fall");
      host.sel(1'b1);
      host.sel(1'b0);
      host.bits(32'h06000000, 8);
      host.pins(1'b0, 1'b0);
      host.step(6);
      host.sel(1'b1);
      host.pins(1'b0, 1'b1);
      host.step(8);
      chk(write_enable_latch, 0, "frame dropped in hold");
   endtask : t_hold

   task automatic t_quad;
      hv = 1'b1;
      host.step(8);
      chk(accel, 1, "accelerated timing");
      hv = 1'b0;
      host.step(8);
      chk(accel, 0, "normal timing");
      register_write_cmd(8'h80, 8'h22);
      chk(quad, 1, "quad mode on");
      chk({vol, frz, origin}, 3'h5, "config after quad write");
      hv = 1'b1;
      wp = 1'b0;
      host.pins(1'b0, 1'b0);
      host.step(8);
      chk({accel, io2, io3, hold_act, hardware_protect_mode}, 0, "quad low");
      wp = 1'b1;
      host.pins(1'b0, 1'b1);
      host.step(8);
      chk({io2, io3}, 2'h3, "quad data lines");
   endtask : t_quad

   initial begin
      repeat (12) @(posedge mclk_i);
      #1;
      nrst_i = 1'b1;
      host.step(6);
      chk({write_enable_latch, bp}, 4'h7, "reset latch and code");
      chk({vol, frz}, 2'h2, "reset volatile and freeze");
      register_write_cmd(8'h00, 8'h00);
      t_commands;
      t_protect;
      t_hwprot;
      t_hold;
      t_quad;
      report_and_stop;
   end

   // Hang guard
   initial begin
      repeat (120000) @(posedge mclk_i);
      n_mismatch++;
      report_and_stop;
   end
endmodule : sfwg_guard_tb_top
`default_nettype wire
